// *** design/sync_mem_port.sv ***
// Programmable synchronous memory port: per-space settings, request crossing, pin sequencer
`timescale 1ns/1ps

module sync_mem_port #(
    parameter int NUM_SPACES = sync_mem_pkg::NUM_SPACES,
    parameter int SPACE_W = sync_mem_pkg::SPACE_W,
    parameter int ADDR_W = sync_mem_pkg::ADDR_W,
    parameter int DATA_W = sync_mem_pkg::DATA_W,
    parameter int BE_W = sync_mem_pkg::BE_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic link_clk_a,
    input wire logic link_clk_b,
    input wire logic sec_wr_en,
    input wire logic [SPACE_W-1:0] sec_wr_space,
    input wire logic [sync_mem_pkg::SEC_W-1:0] sec_wr_data,
    input wire logic [SPACE_W-1:0] sec_rd_space,
    output logic [sync_mem_pkg::SEC_W-1:0] sec_rd_data,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [SPACE_W-1:0] req_space,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [BE_W-1:0] req_be_n,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic mem_clk_out_a,
    output logic mem_clk_out_b,
    output logic [NUM_SPACES-1:0] space_chip_select_n,
    output logic [ADDR_W-1:0] mem_addr_bus,
    output logic [BE_W-1:0] mem_byte_en_n,
    output logic addr_strobe_or_rd_en_n,
    output logic sync_out_en_n,
    output logic sync_wr_en_n,
    input wire logic [DATA_W-1:0] mem_data_bus_in,
    output logic [DATA_W-1:0] mem_data_bus_out,
    output logic mem_data_bus_oe
);
    import sync_mem_pkg::*;

    // ---------------------------------------------------------------
    // Decoding helpers
    // ---------------------------------------------------------------
    function automatic logic [NUM_SPACES-1:0] space_select_n(
        input logic [SPACE_W-1:0] space,
        input logic en
    );
        logic [NUM_SPACES-1:0] sel;
        sel = '1;
        for (int i = 0; i < NUM_SPACES; i++) begin
            if (en && (space == i[SPACE_W-1:0])) begin
                sel[i] = PIN_ACT_N;
            end
        end
        return sel;
    endfunction : space_select_n

    // ---------------------------------------------------------------
    // Secondary control registers, one per space
    // ---------------------------------------------------------------
    logic [SEC_W-1:0] space_secondary_ctrl_ff [NUM_SPACES];

    generate
        for (genvar g = 0; g < NUM_SPACES; g++) begin : g_sec
            wire sec_hit = sec_wr_en && (sec_wr_space == SPACE_W'(g));
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    space_secondary_ctrl_ff[g] <= SEC_RESET;
                end else if (sec_hit) begin
                    space_secondary_ctrl_ff[g] <= sec_wr_data;
                end
            end
        end
    endgenerate

    assign sec_rd_data = space_secondary_ctrl_ff[sec_rd_space];

    // ---------------------------------------------------------------
    // Request hold registers (mclk), stable while the link works
    // ---------------------------------------------------------------
    logic busy_ff;
    logic req_tgl_ff;
    logic hold_write_ff;
    logic [SPACE_W-1:0] hold_space_ff;
    logic [ADDR_W-1:0] hold_addr_ff;
    logic [BE_W-1:0] hold_be_n_ff;
    logic [DATA_W-1:0] hold_wdata_ff;
    logic [SEC_W-1:0] hold_cfg_ff;
    logic rsp_valid_ff;
    logic [DATA_W-1:0] rsp_rdata_ff;
    logic done_pulse;
    logic [DATA_W-1:0] link_rdata_ff;

    wire req_take = req_valid && !busy_ff;

    assign req_ready = !busy_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_rdata = rsp_rdata_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
            req_tgl_ff <= 1'b0;
            hold_write_ff <= 1'b0;
            hold_space_ff <= '0;
            hold_addr_ff <= '0;
            hold_be_n_ff <= '1;
            hold_wdata_ff <= '0;
            hold_cfg_ff <= SEC_RESET;
        end else if (req_take) begin
            busy_ff <= 1'b1;
            req_tgl_ff <= ~req_tgl_ff;
            hold_write_ff <= req_write;
            hold_space_ff <= req_space;
            hold_addr_ff <= req_addr;
            hold_be_n_ff <= req_be_n;
            hold_wdata_ff <= req_wdata;
            hold_cfg_ff <= space_secondary_ctrl_ff[req_space];
        end else if (done_pulse) begin
            busy_ff <= 1'b0;
        end
    end

    // Link result is frozen until the next request, so a word crossing is safe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_ff <= 1'b0;
            rsp_rdata_ff <= '0;
        end else begin
            rsp_valid_ff <= done_pulse;
            if (done_pulse) begin
                rsp_rdata_ff <= link_rdata_ff;
            end
        end
    end

    // ---------------------------------------------------------------
    // Output clock selection
    // ---------------------------------------------------------------
    // Limitation: plain mux, a space with another clock must follow an idle gap
    wire cfg_clk_b = hold_cfg_ff[SEC_CLK_BIT] == CLK_SEL_B;
    wire link_clk = cfg_clk_b ? link_clk_b : link_clk_a;

    assign mem_clk_out_a = link_clk_a;
    assign mem_clk_out_b = link_clk_b;

    // ---------------------------------------------------------------
    // Crossings
    // ---------------------------------------------------------------
    logic start_pulse;
    logic done_tgl_ff;

    toggle_pulse_sync u_req_sync (
        .clk(link_clk),
        .rst_n(rst_n),
        .tgl_in(req_tgl_ff),
        .pulse_out(start_pulse)
    );

    toggle_pulse_sync u_done_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .tgl_in(done_tgl_ff),
        .pulse_out(done_pulse)
    );

    // ---------------------------------------------------------------
    // Link sequencer (selected output clock)
    // ---------------------------------------------------------------
    link_state_type state_ff;
    link_state_type nxt_state;
    logic [LAT_W-1:0] cnt_ff;
    logic [LAT_W-1:0] nxt_cnt;

    wire [LAT_W-1:0] cfg_rl = hold_cfg_ff[SEC_RL_LSB +: LAT_W];
    wire [LAT_W-1:0] cfg_wl = hold_cfg_ff[SEC_WL_LSB +: LAT_W];
    wire cfg_csx = hold_cfg_ff[SEC_CSX_BIT] == CSX_ON;
    wire cfg_role_ads = hold_cfg_ff[SEC_ROLE_BIT] == ROLE_ADDR_STROBE;
    wire [LAT_W-1:0] end_cnt = hold_write_ff ? cfg_wl : cfg_rl;
    wire at_end = (state_ff == LINK_ACCESS) && (cnt_ff == end_cnt);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            LINK_IDLE: begin
                if (start_pulse) begin
                    nxt_state = LINK_ACCESS;
                    nxt_cnt = CNT_ZERO;
                end
            end
            LINK_ACCESS: begin
                if (cnt_ff == end_cnt) begin
                    nxt_state = cfg_role_ads ? LINK_DESEL : LINK_IDLE;
                end else begin
                    nxt_cnt = cnt_ff + CNT_ONE;
                end
            end
            LINK_DESEL: begin
                nxt_state = LINK_IDLE;
            end
            default: begin
                nxt_state = LINK_IDLE;
            end
        endcase
    end

    // Pins are decoded from the next state and registered, so they launch on the edge
    wire in_acc = nxt_state == LINK_ACCESS;
    wire is_cmd = in_acc && (nxt_cnt == CNT_ZERO);
    wire rd_win = in_acc && !hold_write_ff;
    wire nxt_cs = is_cmd || (cfg_csx && rd_win);
    wire nxt_strobe = is_cmd && (cfg_role_ads || !hold_write_ff);
    wire nxt_we = is_cmd && hold_write_ff;
    wire nxt_doe = in_acc && hold_write_ff && (nxt_cnt == cfg_wl);

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= LINK_IDLE;
            cnt_ff <= CNT_ZERO;
            done_tgl_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            if (at_end) begin
                done_tgl_ff <= ~done_tgl_ff;
            end
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_rdata_ff <= '0;
        end else if (at_end && !hold_write_ff) begin
            link_rdata_ff <= mem_data_bus_in;
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            space_chip_select_n <= '1;
            mem_addr_bus <= '0;
            mem_byte_en_n <= '1;
            addr_strobe_or_rd_en_n <= PIN_INACT_N;
            sync_out_en_n <= PIN_INACT_N;
            sync_wr_en_n <= PIN_INACT_N;
            mem_data_bus_out <= '0;
            mem_data_bus_oe <= 1'b0;
        end else begin
            space_chip_select_n <= space_select_n(hold_space_ff, nxt_cs);
            mem_addr_bus <= hold_addr_ff;
            mem_byte_en_n <= in_acc ? hold_be_n_ff : '1;
            addr_strobe_or_rd_en_n <= nxt_strobe ? PIN_ACT_N : PIN_INACT_N;
            sync_out_en_n <= rd_win ? PIN_ACT_N : PIN_INACT_N;
            sync_wr_en_n <= nxt_we ? PIN_ACT_N : PIN_INACT_N;
            mem_data_bus_out <= hold_wdata_ff;
            mem_data_bus_oe <= nxt_doe;
        end
    end

endmodule : sync_mem_port

// *** design/toggle_pulse_sync.sv ***
// Toggle-to-pulse crossing into the receiving clock domain
`timescale 1ns/1ps

module toggle_pulse_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tgl_in,
    output logic pulse_out
);

    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // ---------------------------------------------------------------
    // Two-stage synchroniser, edge taken after the second stage only
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= tgl_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign pulse_out = sync_ff ^ last_ff;

endmodule : toggle_pulse_sync

// *** dv/sram_far_model.sv ***
// Behavioural pipelined synchronous memory on the far side of the port
`timescale 1ns/1ps

module sram_far_model (
    input wire logic clk,
    input wire logic [1:0] rl,
    input wire logic [3:0] adr,
    input wire logic oe_n,
    input wire logic d_oe,
    input wire logic [63:0] d_out,
    output logic [63:0] d_in
);
    logic [63:0] mem [16];
    logic [1:0] cnt_ff;
    // Valid only in the sampling cycle; inverse elsewhere so a wrong edge shows
    assign d_in = (!oe_n && cnt_ff == rl) ? mem[adr] : ~mem[adr];
    always @(posedge clk) begin
        cnt_ff <= oe_n ? 2'h0 : cnt_ff + 2'h1;
        if (d_oe) begin
            mem[adr] <= d_out;
        end
    end
endmodule : sram_far_model

// *** dv/sync_mem_port_props.sv ***
// Pin-level assertions for the synchronous memory port
`timescale 1ns/1ps

module sync_mem_port_props #(
    parameter int NUM_SPACES = 4,
    parameter int BE_W = 8
) (
    input wire logic mem_clk_out_a,
    input wire logic rst_n,
    input wire logic [NUM_SPACES-1:0] space_chip_select_n,
    input wire logic [BE_W-1:0] req_be_n,
    input wire logic [BE_W-1:0] mem_byte_en_n,
    input wire logic addr_strobe_or_rd_en_n,
    input wire logic sync_out_en_n,
    input wire logic sync_wr_en_n,
    input wire logic mem_data_bus_oe,
    input wire logic [sync_mem_pkg::SEC_W-1:0] sec_rd_data
);
    import sync_mem_pkg::*;
    // Judged on clock a only; bench keeps readback on the active space
    wire logic on_a = sec_rd_data[SEC_CLK_BIT] != CLK_SEL_B;
    wire logic csx = sec_rd_data[SEC_CSX_BIT];
    wire logic role = sec_rd_data[SEC_ROLE_BIT];
    wire logic [1:0] rl = sec_rd_data[SEC_RL_LSB+:2];
    wire logic [1:0] wl = sec_rd_data[SEC_WL_LSB+:2];
    wire logic cs_hi = &space_chip_select_n;
    wire logic rcmd = on_a && !cs_hi && !addr_strobe_or_rd_en_n && !sync_out_en_n;
    wire logic wcmd = on_a && !sync_wr_en_n;
    default clocking @(posedge mem_clk_out_a); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_rd_lat0; rcmd && rl == 2'h0 |=> sync_out_en_n; endproperty
    a_rd_lat0: assert property (p_rd_lat0) else $error("read lat 0 oe");
    property p_rd_lat3; rcmd && rl == 2'h3 |-> !sync_out_en_n [*4] ##1 sync_out_en_n; endproperty
    a_rd_lat3: assert property (p_rd_lat3) else $error("read lat 3 oe");
    property p_wr_lat0; wcmd && wl == 2'h0 |-> mem_data_bus_oe ##1 !mem_data_bus_oe; endproperty
    a_wr_lat0: assert property (p_wr_lat0) else $error("write lat 0 data");
    property p_wr_lat2;
        wcmd && wl == 2'h2 |-> !mem_data_bus_oe [*2] ##1 mem_data_bus_oe ##1 !mem_data_bus_oe;
    endproperty
    a_wr_lat2: assert property (p_wr_lat2) else $error("write lat 2 data");
    property p_cs_short; wcmd || (rcmd && !csx) |=> cs_hi; endproperty
    a_cs_short: assert property (p_cs_short) else $error("cs held after cmd");
    property p_cs_ext; !sync_out_en_n && csx && on_a |-> !cs_hi; endproperty
    a_cs_ext: assert property (p_cs_ext) else $error("cs dropped under oe");
    property p_desel; on_a && !role && $rose(sync_out_en_n) |-> (cs_hi && addr_strobe_or_rd_en_n) [*2]; endproperty
    a_desel: assert property (p_desel) else $error("no deselect cycle");
    property p_role_re; wcmd && role |-> addr_strobe_or_rd_en_n; endproperty
    a_role_re: assert property (p_role_re) else $error("read enable on write");
    property p_we_pin; wcmd |-> sync_out_en_n && !cs_hi; endproperty
    a_we_pin: assert property (p_we_pin) else $error("write strobe pin misuse");
    // Bench holds the request fields until the next request, so the command can be compared
    property p_be_cmd; rcmd || wcmd |-> mem_byte_en_n == req_be_n; endproperty
    a_be_cmd: assert property (p_be_cmd) else $error("byte enables differ from request");
    property p_be_idle; on_a && $rose(sync_out_en_n) |-> &mem_byte_en_n; endproperty
    a_be_idle: assert property (p_be_idle) else $error("byte enables left active");
endmodule : sync_mem_port_props

bind sync_mem_port sync_mem_port_props #(.NUM_SPACES(NUM_SPACES), .BE_W(BE_W))
    sync_mem_port_props_i (
    .mem_clk_out_a, .rst_n, .space_chip_select_n, .req_be_n, .mem_byte_en_n,
    .addr_strobe_or_rd_en_n,
    .sync_out_en_n, .sync_wr_en_n, .mem_data_bus_oe, .sec_rd_data
);

// *** dv/sync_mem_port_tb.sv ***
// Self-checking bench for the synchronous memory port
`timescale 1ns/1ps

module sync_mem_port_tb;
    import sync_mem_pkg::*;
    logic mclk = 0, rst_n = 0, link_clk_a = 0, link_clk_b = 0, run_a = 1, use_b = 0;
    logic sec_wr_en = 0, req_valid = 0, req_write = 0, req_ready, rsp_valid;
    logic [1:0] sec_wr_space = 0, sec_rd_space = 0, req_space = 0, mdl_rl = 0;
    logic [6:0] sec_wr_data = 0, sec_rd_data;
    logic [19:0] req_addr = 0, mem_addr_bus;
    logic [7:0] req_be_n = 8'hff;
    logic [63:0] req_wdata = 0, rsp_rdata, mem_data_bus_in, mem_data_bus_out, rd;
    logic mem_clk_out_a, mem_clk_out_b, sync_out_en_n, mem_data_bus_oe;
    int fail_count = 0, cmp_count = 0;
    wire logic mdl_clk = use_b ? mem_clk_out_b : mem_clk_out_a;

    always #50 mclk = ~mclk;
    always #16 if (run_a) link_clk_a = ~link_clk_a;
    // Offset once so clock b keeps a fixed 7 ns phase shift to clock a at the same period
    always begin
        if ($time == 0) #7;
        #16 link_clk_b = ~link_clk_b;
    end

    sync_mem_port sync_mem_port_i (.mclk, .rst_n, .link_clk_a, .link_clk_b, .sec_wr_en,
        .sec_wr_space, .sec_wr_data, .sec_rd_space, .sec_rd_data, .req_valid, .req_ready,
        .req_write, .req_space, .req_addr, .req_be_n, .req_wdata, .rsp_valid,
        .rsp_rdata, .mem_clk_out_a, .mem_clk_out_b, .space_chip_select_n(), .mem_addr_bus,
        .mem_byte_en_n(), .addr_strobe_or_rd_en_n(), .sync_out_en_n, .sync_wr_en_n(),
        .mem_data_bus_in, .mem_data_bus_out, .mem_data_bus_oe);
    sram_far_model sram_far_model_i (.clk(mdl_clk), .rl(mdl_rl), .adr(mem_addr_bus[3:0]),
        .oe_n(sync_out_en_n), .d_oe(mem_data_bus_oe), .d_out(mem_data_bus_out),
        .d_in(mem_data_bus_in));

    task automatic give_verdict();
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    task automatic set_sec(input logic [1:0] sp, input logic [6:0] w);
        @(negedge mclk);
        sec_wr_en = 1;
        sec_wr_space = sp;
        sec_wr_data = w;
        sec_rd_space = sp;
        req_space = sp;
        mdl_rl = w[1:0];
        @(negedge mclk);
        sec_wr_en = 0;
    endtask : set_sec

    // Request held until the edge that samples ready, then one bounded wait for the answer
    task automatic xfer(input logic wr, input logic [19:0] ad, input logic [63:0] wd);
        int n;
        @(negedge mclk);
        req_valid = 1;
        req_write = wr;
        req_addr = ad;
        req_wdata = wd;
        req_be_n = 8'(ad) ^ 8'ha5;
        n = 0;
        @(posedge mclk);
        while (req_ready !== 1'b1 && n < 50) begin
            n++;
            @(posedge mclk);
        end
        if (n >= 50) begin
            fail_count++;
            $display("MISMATCH req_ready exp 1 got %b", req_ready);
            give_verdict();
        end
        @(negedge mclk);
        req_valid = 0;
        for (n = 0; n < 400 && rsp_valid !== 1'b1; n++) @(negedge mclk);
        rd = rsp_rdata;
        if (n >= 400) begin
            fail_count++;
            $display("MISMATCH rsp_valid exp 1 got %b", rsp_valid);
            give_verdict();
        end
    endtask : xfer

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_regs();
        chk("sec reset", 64'(SEC_RESET), 64'(sec_rd_data));
        for (int s = 0; s < 4; s++) set_sec(2'(s), 7'(8'h11 * s + 8'h05));
        for (int s = 0; s < 4; s++) begin
            @(negedge mclk);
            sec_rd_space = 2'(s);
            #1;
            chk("sec word", 64'(8'h11 * s + 8'h05), 64'(sec_rd_data));
        end
    endtask : s_regs

    task automatic s_lat();
        for (int l = 0; l < 4; l++) begin
            set_sec(2'h1, {3'h0, 2'(3 - l), 2'(l)});
            xfer(1'b1, 20'(l), 64'h5a3c_0f96_a5c3_f069 + 64'(l));
            xfer(1'b0, 20'(l), 64'h0);
            chk("latency read", 64'h5a3c_0f96_a5c3_f069 + 64'(l), rd);
        end
    endtask : s_lat

    task automatic s_fifo();
        set_sec(2'h2, 7'h36);
        xfer(1'b1, 20'h8, 64'h1111_2222_3333_4444);
        xfer(1'b1, 20'h9, 64'h8888_7777_6666_5555);
        xfer(1'b0, 20'h8, 64'h0);
        chk("fifo read a", 64'h1111_2222_3333_4444, rd);
        xfer(1'b0, 20'h9, 64'h0);
        chk("fifo read b", 64'h8888_7777_6666_5555, rd);
    endtask : s_fifo

    // Clock a is stopped, so an access timed from it cannot finish
    task automatic s_clkb();
        set_sec(2'h3, 7'h4b);
        repeat (4) @(negedge mclk);
        use_b = 1;
        run_a = 0;
        xfer(1'b1, 20'hf, 64'hdead_0bad_f00d_cafe);
        xfer(1'b0, 20'hf, 64'h0);
        chk("clock b read", 64'hdead_0bad_f00d_cafe, rd);
        run_a = 1;
    endtask : s_clkb

    initial begin
        repeat (20) @(negedge mclk);
        rst_n = 1;
        s_regs();
        s_lat();
        s_fifo();
        s_clkb();
        give_verdict();
    end
endmodule : sync_mem_port_tb

// *** shared/sync_mem_pkg.sv ***
// Shared constants and types for the programmable synchronous memory port
package sync_mem_pkg;

    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int NUM_SPACES = 4;
    localparam int SPACE_W = 2;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 64;
    localparam int BE_W = 8;
    localparam int LAT_W = 2;

    // ---------------------------------------------------------------
    // Secondary control word layout
    // ---------------------------------------------------------------
    localparam int SEC_W = 7;
    localparam int SEC_RL_LSB = 0;
    localparam int SEC_WL_LSB = 2;
    localparam int SEC_CSX_BIT = 4;
    localparam int SEC_ROLE_BIT = 5;
    localparam int SEC_CLK_BIT = 6;
    localparam logic [SEC_W-1:0] SEC_RESET = 7'h00;

    // ---------------------------------------------------------------
    // Pin levels and encodings
    // ---------------------------------------------------------------
    localparam logic PIN_ACT_N = 1'b0;
    localparam logic PIN_INACT_N = 1'b1;
    localparam logic ROLE_ADDR_STROBE = 1'b0;
    localparam logic ROLE_READ_EN = 1'b1;
    localparam logic CSX_ON = 1'b1;
    localparam logic CLK_SEL_B = 1'b1;
    localparam logic [LAT_W-1:0] CNT_ZERO = 2'h0;
    localparam logic [LAT_W-1:0] CNT_ONE = 2'h1;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_ACCESS,
        LINK_DESEL
    } link_state_type;

endpackage : sync_mem_pkg
